/* File: logic/mfs_supervisor.sv */
// Motion fault supervisor: fault detection, latching, history and Wishbone access
module mfs_supervisor
#(
  parameter int unsigned HIST_DEPTH = mfs_pkg::HIST_DEPTH,
  parameter int unsigned NV_DEPTH   = mfs_pkg::NV_DEPTH
)
(
  input  wire logic             I_CLK,
  input  wire logic             I_RSTN,
  input  wire logic             I_ENABLE,
  input  wire mfs_pkg::mfs_meas_t I_MEAS,
  input  wire logic             I_WB_CYC,
  input  wire logic             I_WB_STB,
  input  wire logic             I_WB_WE,
  input  wire logic [7:0]       I_WB_ADR,
  input  wire logic [3:0]       I_WB_SEL,
  input  wire logic [31:0]      I_WB_DAT,
  output logic      [31:0]      O_WB_DAT,
  output logic                  O_WB_ACK,
  output logic                  O_FAULT_LAMP,
  output logic                  O_MOTION_EN,
  output logic                  O_IRQ,
  output logic                  O_CTRL_RESET
);
  localparam int unsigned NF = mfs_pkg::N_FAULT;

  logic [NF-1:0] active_r;
  logic [NF-1:0] status_r;
  logic [15:0]   mask_r;
  logic [15:0]   limrev_r, limfwd_r, maxspd_r, spderr_r, tmo_r, curerr_r;
  logic [7:0]    hist_r [HIST_DEPTH];
  logic [4:0]    hcount_r;
  logic          enable_d_r;
  logic [NF-1:0] det;
  logic [NF-1:0] new_fault;
  logic [7:0]    new_code;
  logic          wr_stb, rd_stb, ctrl_rst_wr;
  logic [16:0]   spd_diff;
  logic [16:0]   overrun;
  logic          clr_evt;

  function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
    abs_diff = (a > b) ? a - b : b - a;
  endfunction

  // One-hot status bit of a fault code; code 00 gives no bit
  function automatic logic [NF-1:0] code_bit(input logic [7:0] code);
    code_bit = '0;
    if (code != 8'h00)
      code_bit = NF'(1) << (code - 8'h01);
  endfunction

  assign wr_stb = I_WB_CYC && I_WB_STB && I_WB_WE && !O_WB_ACK;
  assign rd_stb = I_WB_CYC && I_WB_STB && !I_WB_WE && !O_WB_ACK;
  assign ctrl_rst_wr = wr_stb && (I_WB_ADR == mfs_pkg::REG_CTRL) && I_WB_SEL[0]
                       && I_WB_DAT[mfs_pkg::CTRL_RESET_BIT];
  // Enable rising edge or host reset; system failures survive both
  assign clr_evt = ctrl_rst_wr || (I_ENABLE && !enable_d_r);

  // Fault detection
  always_comb
  begin
    spd_diff = {1'b0, abs_diff(I_MEAS.vel_cmd, I_MEAS.vel)};
    overrun  = {1'b0, I_MEAS.move_time} - {1'b0, I_MEAS.move_cmd_time};
    det = '0;
    det[mfs_pkg::F_ADC - 1]    = I_MEAS.adc_ref_low;
    det[mfs_pkg::F_BRAKE - 1]  = I_MEAS.brake_over;
    det[mfs_pkg::F_POS - 1]    = I_MEAS.pos_fail;
    det[mfs_pkg::F_REVLIM - 1] = I_MEAS.pos < limrev_r;
    det[mfs_pkg::F_FWDLIM - 1] = I_MEAS.pos > limfwd_r;
    det[mfs_pkg::F_SPEED - 1]  = I_MEAS.vel > maxspd_r;
    det[mfs_pkg::F_SPDFOL - 1] = I_MEAS.moving && spd_diff[15:0] > spderr_r;
    det[mfs_pkg::F_ENABLE - 1] = I_MEAS.move_req && !I_ENABLE;
    det[mfs_pkg::F_TMO - 1]    = I_MEAS.moving && !overrun[16]
                                 && overrun[15:0] >= tmo_r;
    det[mfs_pkg::F_CURFOL - 1] = I_MEAS.cur_err > curerr_r;
  end

  assign new_fault = det & ~active_r;

  // Lowest code wins when several arrive together; the rest follow one per cycle after
  always_comb
  begin
    new_code = 8'h00;
    for (int i = NF - 1; i >= 0; i--)
      if (new_fault[i])
        new_code = 8'(i + 1);
  end

  // Active fault latches
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      active_r <= '0;
    else
    begin
      if (clr_evt)
        active_r <= (active_r & mfs_pkg::SYS_FAIL_MASK) | (det & mfs_pkg::SYS_FAIL_MASK);
      else if (new_code != 8'h00)
        active_r <= active_r | code_bit(new_code);
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      enable_d_r <= 1'b0;
    else
      enable_d_r <= I_ENABLE;
  end

  // History shift register, newest in slot 0
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      for (int i = 0; i < HIST_DEPTH; i++)
        hist_r[i] <= 8'h00;
      hcount_r <= '0;
    end
    else if (new_code != 8'h00 && !clr_evt)
    begin
      hist_r[0] <= new_code;
      for (int i = 1; i < HIST_DEPTH; i++)
        hist_r[i] <= hist_r[i-1];
      if (hcount_r != 5'(HIST_DEPTH))
        hcount_r <= hcount_r + 5'h01;
    end
  end

  // Sticky interrupt status, set wins over write-one-to-clear
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      status_r <= '0;
    else
    begin
      logic [NF-1:0] clr;
      logic [NF-1:0] setv;
      clr = '0;
      setv = '0;
      setv = code_bit(new_code);
      if (wr_stb && I_WB_ADR == mfs_pkg::REG_STATUS)
        clr = I_WB_DAT[NF-1:0];
      status_r <= (status_r & ~clr) | setv;
    end
  end

  // Configuration registers
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      mask_r   <= mfs_pkg::MASK_RST;
      limrev_r <= mfs_pkg::LIMREV_RST;
      limfwd_r <= mfs_pkg::LIMFWD_RST;
      maxspd_r <= mfs_pkg::MAXSPD_RST;
      spderr_r <= mfs_pkg::SPDERR_RST;
      tmo_r    <= mfs_pkg::TMO_RST;
      curerr_r <= mfs_pkg::CURERR_RST;
    end
    else if (wr_stb && I_WB_SEL[1:0] == 2'b11)
    begin
      case (I_WB_ADR)
        mfs_pkg::REG_MASK:   mask_r   <= I_WB_DAT[15:0];
        mfs_pkg::REG_LIMREV: limrev_r <= I_WB_DAT[15:0];
        mfs_pkg::REG_LIMFWD: limfwd_r <= I_WB_DAT[15:0];
        mfs_pkg::REG_MAXSPD: maxspd_r <= I_WB_DAT[15:0];
        mfs_pkg::REG_SPDERR: spderr_r <= I_WB_DAT[15:0];
        mfs_pkg::REG_TMO:    tmo_r    <= I_WB_DAT[15:0];
        mfs_pkg::REG_CURERR: curerr_r <= I_WB_DAT[15:0];
        default: ;
      endcase
    end
  end

  // Bus answer one cycle after the strobe, dropped the cycle after
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= '0;
    end
    else
    begin
      O_WB_ACK <= (wr_stb || rd_stb);
      O_WB_DAT <= '0;
      if (rd_stb)
      begin
        if (I_WB_ADR >= mfs_pkg::REG_HIST0 && I_WB_ADR <= mfs_pkg::REG_HISTEND)
          O_WB_DAT <= {24'h0, hist_r[4'(I_WB_ADR[5:2])]};
        else
          case (I_WB_ADR)
            mfs_pkg::REG_STATUS: O_WB_DAT <= {22'h0, status_r};
            mfs_pkg::REG_MASK:   O_WB_DAT <= {16'h0, mask_r};
            mfs_pkg::REG_ACTIVE: O_WB_DAT <= {22'h0, active_r};
            mfs_pkg::REG_IO:     O_WB_DAT <= {27'h0, I_MEAS.moving, I_MEAS.move_req,
                                              O_FAULT_LAMP, O_MOTION_EN, I_ENABLE};
            mfs_pkg::REG_HCOUNT: O_WB_DAT <= {27'h0, hcount_r};
            mfs_pkg::REG_LIMREV: O_WB_DAT <= {16'h0, limrev_r};
            mfs_pkg::REG_LIMFWD: O_WB_DAT <= {16'h0, limfwd_r};
            mfs_pkg::REG_MAXSPD: O_WB_DAT <= {16'h0, maxspd_r};
            mfs_pkg::REG_SPDERR: O_WB_DAT <= {16'h0, spderr_r};
            mfs_pkg::REG_TMO:    O_WB_DAT <= {16'h0, tmo_r};
            mfs_pkg::REG_CURERR: O_WB_DAT <= {16'h0, curerr_r};
            default:             O_WB_DAT <= '0;
          endcase
      end
    end
  end

  // Outputs registered; motion blocked by disable or any active fault
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      O_FAULT_LAMP <= 1'b0;
      O_MOTION_EN  <= 1'b0;
      O_IRQ        <= 1'b0;
      O_CTRL_RESET <= 1'b0;
    end
    else
    begin
      O_FAULT_LAMP <= |active_r;
      O_MOTION_EN  <= I_ENABLE && !(|active_r);
      O_IRQ        <= |(status_r & mask_r[NF-1:0]);
      O_CTRL_RESET <= ctrl_rst_wr;
    end
  end

  // Checks
  a_sysfail_sticky: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    active_r[0] |=> active_r[0]) else $error("System fault 01 cleared");
  a_brake_sticky: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    active_r[1] |=> active_r[1]) else $error("System fault 02 cleared");
  a_enable_clears: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (I_ENABLE && !enable_d_r) |=> (active_r[NF-1:2] == '0))
    else $error("Enable edge did not clear faults");
  a_lamp_follows: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (|active_r) |=> O_FAULT_LAMP) else $error("Lamp off with fault");
  a_motion_gate: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    O_MOTION_EN |-> $past(I_ENABLE)) else $error("Motion without enable");
  a_enable_fault: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (I_MEAS.move_req && !I_ENABLE && !clr_evt
     && new_fault[mfs_pkg::F_ENABLE - 2:0] == '0)
    |=> active_r[mfs_pkg::F_ENABLE - 1]) else $error("Fault 08 missed");
  a_adc_fault: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    I_MEAS.adc_ref_low |=> active_r[0]) else $error("Fault 01 missed");
  a_hist_push: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (new_code != 8'h00 && !ctrl_rst_wr && !(I_ENABLE && !enable_d_r))
    |=> hist_r[0] == $past(new_code) && hist_r[1] == $past(hist_r[0]))
    else $error("History push wrong");
  a_hist_count: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    hcount_r <= 5'(HIST_DEPTH)) else $error("History count overflow");
  a_ack_pulse: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    O_WB_ACK |=> !O_WB_ACK) else $error("Ack held two cycles");

  // Latching, history and status checks
  a_fault_latch: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (new_code != 8'h00 && !clr_evt)
    |=> (active_r & $past(code_bit(new_code))) != '0)
    else $error("New fault not latched");

  a_status_set: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (new_code != 8'h00)
    |=> (status_r & $past(code_bit(new_code))) == $past(code_bit(new_code)))
    else $error("Status bit not set");

  a_status_w1c: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (wr_stb && I_WB_ADR == mfs_pkg::REG_STATUS && new_code == 8'h00)
    |=> (status_r & $past(I_WB_DAT[NF-1:0])) == '0)
    else $error("Status bit not cleared");

  a_hcount_step: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (new_code != 8'h00 && !clr_evt && hcount_r != 5'(HIST_DEPTH))
    |=> hcount_r == $past(hcount_r) + 5'h01)
    else $error("History count not advanced");

  a_hist_hold: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (new_code == 8'h00 || clr_evt)
    |=> $stable(hcount_r) && hist_r[0] == $past(hist_r[0]))
    else $error("History moved without a fault");

  a_hist_read: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (rd_stb && I_WB_ADR == mfs_pkg::REG_HIST0)
    |=> O_WB_DAT == {24'h0, $past(hist_r[0])})
    else $error("Newest history slot misread");

  // Bus and output checks
  a_ack_answer: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (wr_stb || rd_stb)
    |=> O_WB_ACK)
    else $error("Bus request not acked");

  a_rdata_idle: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    !O_WB_ACK
    |-> O_WB_DAT == '0)
    else $error("Read data without ack");

  a_limit_write: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (wr_stb && I_WB_ADR == mfs_pkg::REG_LIMREV && I_WB_SEL[1:0] == 2'b11)
    |=> limrev_r == $past(I_WB_DAT[15:0]))
    else $error("Reverse limit write lost");

  a_cfg_guard: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (wr_stb && I_WB_SEL[1:0] != 2'b11)
    |=> $stable(mask_r) && $stable(limfwd_r))
    else $error("Partial write changed config");

  a_ctrl_pulse: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    ctrl_rst_wr
    |=> O_CTRL_RESET)
    else $error("Controller reset pulse missing");

  a_motion_block: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (|active_r)
    |=> !O_MOTION_EN)
    else $error("Motion allowed with fault");

  a_motion_on: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (I_ENABLE && active_r == '0)
    |=> O_MOTION_EN)
    else $error("Motion blocked without cause");

  a_lamp_clear: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (active_r == '0)
    |=> !O_FAULT_LAMP)
    else $error("Lamp lit without fault");

  a_irq_level: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    1'b1
    |=> O_IRQ == $past(|(status_r & mask_r[NF-1:0])))
    else $error("Interrupt level wrong");

  c_fault_raised: cover property (@(posedge I_CLK) disable iff (!I_RSTN) $rose(O_FAULT_LAMP));
  c_hist_full: cover property (@(posedge I_CLK) disable iff (!I_RSTN) hcount_r == 5'(HIST_DEPTH));
  c_enable_clear: cover property (@(posedge I_CLK) disable iff (!I_RSTN) $fell(O_FAULT_LAMP));
  c_irq: cover property (@(posedge I_CLK) disable iff (!I_RSTN) $rose(O_IRQ));
  c_sys_fail: cover property (@(posedge I_CLK) disable iff (!I_RSTN) active_r[1:0] != 2'b00);
endmodule

/* File: logic/mfs_pkg.sv */
// Package for the motion fault supervisor: register map, fault codes, layouts
package mfs_pkg;
  localparam int unsigned CLK_HZ     = 25000000;
  localparam int unsigned HIST_DEPTH = 16;
  localparam int unsigned NV_DEPTH   = 15;

  // Register byte offsets
  localparam logic [7:0] REG_STATUS  = 8'h00;
  localparam logic [7:0] REG_MASK    = 8'h04;
  localparam logic [7:0] REG_CTRL    = 8'h08;
  localparam logic [7:0] REG_ACTIVE  = 8'h0c;
  localparam logic [7:0] REG_IO      = 8'h10;
  localparam logic [7:0] REG_HCOUNT  = 8'h14;
  localparam logic [7:0] REG_LIMREV  = 8'h18;
  localparam logic [7:0] REG_LIMFWD  = 8'h1c;
  localparam logic [7:0] REG_MAXSPD  = 8'h20;
  localparam logic [7:0] REG_SPDERR  = 8'h24;
  localparam logic [7:0] REG_TMO     = 8'h28;
  localparam logic [7:0] REG_CURERR  = 8'h2c;
  localparam logic [7:0] REG_HIST0   = 8'h40;
  localparam logic [7:0] REG_HISTEND = 8'h7c;

  // Control register bits
  localparam int unsigned CTRL_RESET_BIT = 0;

  // Reset values of limits and the interrupt mask
  localparam logic [15:0] LIMREV_RST = 16'h0000;
  localparam logic [15:0] LIMFWD_RST = 16'hffff;
  localparam logic [15:0] MAXSPD_RST = 16'hffff;
  localparam logic [15:0] SPDERR_RST = 16'hffff;
  localparam logic [15:0] TMO_RST    = 16'hffff;
  localparam logic [15:0] CURERR_RST = 16'hffff;
  localparam logic [15:0] MASK_RST   = 16'h0000;

  // Fault codes, status bit n-1 belongs to code n
  localparam logic [7:0] F_ADC    = 8'h01;
  localparam logic [7:0] F_BRAKE  = 8'h02;
  localparam logic [7:0] F_POS    = 8'h03;
  localparam logic [7:0] F_REVLIM = 8'h04;
  localparam logic [7:0] F_FWDLIM = 8'h05;
  localparam logic [7:0] F_SPEED  = 8'h06;
  localparam logic [7:0] F_SPDFOL = 8'h07;
  localparam logic [7:0] F_ENABLE = 8'h08;
  localparam logic [7:0] F_TMO    = 8'h09;
  localparam logic [7:0] F_CURFOL = 8'h0a;
  localparam int unsigned N_FAULT = 10;
  localparam logic [9:0] SYS_FAIL_MASK = 10'h003;

  typedef struct packed {
    logic [15:0] pos;
    logic [15:0] vel;
    logic [15:0] vel_cmd;
    logic [15:0] move_time;
    logic [15:0] move_cmd_time;
    logic [15:0] cur_err;
    logic        adc_ref_low;
    logic        brake_over;
    logic        pos_fail;
    logic        move_req;
    logic        moving;
  } mfs_meas_t;
endpackage

/* File: verification/mfs_host.sv */
// Host model: Wishbone classic master that reaches the supervisor registers
module mfs_host
(
  input  wire logic        i_clk,
  input  wire logic        i_ack,
  output logic             o_cyc,
  output logic             o_stb,
  output logic             o_we,
  output logic [7:0]       o_adr,
  output logic [3:0]       o_sel,
  output logic [31:0]      o_dat
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    o_cyc = 1'b0;
    o_stb = 1'b0;
    o_we  = 1'b0;
    o_adr = 8'h00;
    o_sel = 4'h0;
    o_dat = 32'h0;
  end
  // Request held until ack is seen; the bench timeout ends a hang
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    o_cyc <= 1'b1;
    o_stb <= 1'b1;
    o_we  <= w;
    o_adr <= a;
    o_sel <= 4'hf;
    o_dat <= d;
    do @(posedge i_clk); while (i_ack !== 1'b1);
    o_cyc <= 1'b0;
    o_stb <= 1'b0;
    // Released data must not look valid
    o_dat <= ~d;
  endtask
endmodule

/* File: verification/mfs_tb.sv */
// Testbench for the motion fault supervisor
`define CHK(n, e, g) compares++; if ((g) !== (e)) begin errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CODES [8] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h09, 8'h0a, 8'h08};
  logic               clk  = 1'b0;
  logic               rstn = 1'b0;
  logic               en   = 1'b1;
  mfs_pkg::mfs_meas_t meas = '0;
  logic               cyc, stb, we, ack, lamp, mot, irq, crst;
  logic [7:0]         adr;
  logic [3:0]         sel;
  logic [31:0]        wdat, rdat, seed = 32'h807c;
  logic [31:0]        exp_q[$];
  logic [7:0]         hist_q[$];
  int                 errors = 0, compares = 0, cycles = 0, crst_n = 0;
  always #20 clk = ~clk;
  mfs_host u_host (.i_clk(clk), .i_ack(ack), .o_cyc(cyc), .o_stb(stb), .o_we(we),
    .o_adr(adr), .o_sel(sel), .o_dat(wdat));
  mfs_supervisor u_dut (.I_CLK(clk), .I_RSTN(rstn), .I_ENABLE(en), .I_MEAS(meas),
    .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel),
    .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack), .O_FAULT_LAMP(lamp),
    .O_MOTION_EN(mot), .O_IRQ(irq), .O_CTRL_RESET(crst));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Random but fault-free plant state: inside the limits set below
  function automatic mfs_pkg::mfs_meas_t base();
    mfs_pkg::mfs_meas_t m;
    logic [31:0]        r;
    m = '0;
    r = rnd();
    m.pos = 16'h0200 + {2'b00, r[13:0]};
    m.cur_err = {10'h000, r[21:16]};
    return m;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    u_host.xfer(1'b0, a, 32'h0);
  endtask
  task automatic fault(input logic [7:0] c);
    mfs_pkg::mfs_meas_t m;
    m = base();
    case (c)
      8'h01: m.adc_ref_low = 1'b1;
      8'h02: m.brake_over = 1'b1;
      8'h03: m.pos_fail = 1'b1;
      8'h04: m.pos = 16'h0080;
      8'h05: m.pos = 16'h9000;
      8'h06: m.vel = 16'h2000;
      8'h07: {m.moving, m.vel_cmd} = {1'b1, 16'h0200};
      8'h08: m.move_req = 1'b1;
      8'h09: {m.moving, m.move_time, m.move_cmd_time} = {1'b1, 32'h00200010};
      default: m.cur_err = 16'h0041;
    endcase
    @(posedge clk);
    meas <= m;
    if (c == mfs_pkg::F_ENABLE) en <= 1'b0;
    repeat (3) @(posedge clk);
    meas <= base();
    hist_q.push_front(c);
    repeat (2) @(posedge clk);
  endtask
  task automatic complete_run();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Result checker: oldest expectation against each read answer
  always @(posedge clk)
  begin
    cycles++;
    if (crst === 1'b1) crst_n++;
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
    begin
      `CHK("rdata", exp_q[0], rdat)
      void'(exp_q.pop_front());
    end
    if (cycles == 20000)
    begin
      errors++;
      complete_run();
    end
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd(mfs_pkg::REG_LIMFWD, 32'h0000ffff);
    rd(mfs_pkg::REG_HCOUNT, 32'h0);
    rd(8'h30, 32'h0);
    wr(mfs_pkg::REG_LIMREV, 32'h0100);
    wr(mfs_pkg::REG_LIMFWD, 32'h8000);
    wr(mfs_pkg::REG_MAXSPD, 32'h1000);
    wr(mfs_pkg::REG_SPDERR, 32'h0100);
    wr(mfs_pkg::REG_TMO, 32'h0010);
    wr(mfs_pkg::REG_CURERR, 32'h0040);
    wr(mfs_pkg::REG_MASK, 32'h03ff);
    for (int r = 0; r < 3; r++)
    begin
      foreach (CODES[i]) fault(CODES[i]);
      `CHK("lamp", 1'b1, lamp)
      `CHK("motion", 1'b0, mot)
      rd(mfs_pkg::REG_ACTIVE, 32'h3fc);
      if (r == 2) wr(mfs_pkg::REG_CTRL, 32'h1);
      en <= 1'b1;
      repeat (3) @(posedge clk);
      rd(mfs_pkg::REG_ACTIVE, 32'h0);
    end
    `CHK("motion", 1'b1, mot)
    rd(mfs_pkg::REG_IO, 32'h3);
    rd(mfs_pkg::REG_HCOUNT, 32'h10);
    for (int i = 0; i < 16; i++) rd(mfs_pkg::REG_HIST0 + 8'(4 * i), {24'h0, hist_q[i]});
    `CHK("irq", 1'b1, irq)
    rd(mfs_pkg::REG_STATUS, 32'h3fc);
    wr(mfs_pkg::REG_MASK, 32'h0);
    repeat (2) @(posedge clk);
    `CHK("irq", 1'b0, irq)
    wr(mfs_pkg::REG_MASK, 32'h03ff);
    wr(mfs_pkg::REG_STATUS, 32'h3fc);
    repeat (2) @(posedge clk);
    `CHK("irq", 1'b0, irq)
    fault(mfs_pkg::F_ADC);
    fault(mfs_pkg::F_BRAKE);
    rd(mfs_pkg::REG_STATUS, 32'h3);
    en <= 1'b0;
    repeat (2) @(posedge clk);
    en <= 1'b1;
    wr(mfs_pkg::REG_CTRL, 32'h1);
    repeat (3) @(posedge clk);
    rd(mfs_pkg::REG_ACTIVE, 32'h3);
    `CHK("lamp", 1'b1, lamp)
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(mfs_pkg::REG_ACTIVE, 32'h0);
    `CHK("lamp", 1'b0, lamp)
    `CHK("ctrl_reset", 2, crst_n)
    complete_run();
  end
endmodule
